// file: verilog/cpu_ctl_defs.vh
`ifndef CPU_CTL_DEFS_VH
`define CPU_CTL_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SYSCTL_ADDR        16'hFFC4
`define MODECTL_ADDR       16'hFFC5
`define RAM_LO_ADDR        16'hFB80
`define RAM_HI_ADDR        16'hFF7F
`define ROM_HI_ADDR        16'hEF7F
`define REGF_LO_ADDR       16'hFF80
`define CTLREG_LO_ADDR     16'hFFF0

// ----------------------------------------------------------------------
// System control fields and reset
// ----------------------------------------------------------------------
`define SYSCTL_STANDBY_SEL_BIT 7
`define SYSCTL_XRST_BIT    3
`define SYSCTL_RAM_GATE_BIT 0
`define SYSCTL_RST         8'h09
`define SYSCTL_WMASK       8'hF7
`define MODECTL_FIXED      8'hE4

// ----------------------------------------------------------------------
// Own control registers
// ----------------------------------------------------------------------
`define CMD_ADDR           16'hFFF0
`define FLAGS_ADDR         16'hFFF1
`define IMM_ADDR           16'hFFF2
`define CNT_ADDR           16'hFFF3
`define SRC_HI_ADDR        16'hFFF4
`define SRC_LO_ADDR        16'hFFF5
`define DST_HI_ADDR        16'hFFF6
`define DST_LO_ADDR        16'hFFF7
`define SP_HI_ADDR         16'hFFF8
`define SP_LO_ADDR         16'hFFF9
`define PC_HI_ADDR         16'hFFFA
`define PC_LO_ADDR         16'hFFFB
`define STAT_ADDR          16'hFFFC
`define GREG_ADDR          16'hFFFD

// ----------------------------------------------------------------------
// Commands
// ----------------------------------------------------------------------
`define OP_NOP             8'h00
`define OP_FLAG_LD_IMM     8'h01
`define OP_FLAG_LD_REG     8'h02
`define OP_FLAG_ST         8'h03
`define OP_FLAG_AND        8'h04
`define OP_FLAG_OR         8'h05
`define OP_FLAG_XOR        8'h06
`define OP_SLEEP           8'h07
`define OP_MOVE            8'h08
`define OP_IRQ             8'h09
`define OP_EXC_RET         8'h0A
`define OP_WAKE            8'h0B

// ----------------------------------------------------------------------
// Timing, program counter step and flags reset
// ----------------------------------------------------------------------
`define FAST_STATES        2
`define SLOW_STATES        3
`define NOP_PC_STEP        16'h0002
`define FLAGS_RST          8'h80

`endif

// file: verilog/cpu_state_bus_mode_control.v
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ctl_defs.vh"

// Summary of operation
// RULE1: Return command restores program counter and flags saved at exception entry.
// RULE2: Halt with standby select clear enters sleep; registers kept, modules run.
// RULE3: Flags load writes immediate byte or general register byte into flags.
// RULE4: Flags store copies the whole flags byte into the general register.
// RULE5: Flag logic commands AND, OR or XOR flags with immediate byte.
// RULE6: No-operation only advances the program counter by two.
// RULE7: Block move copies byte, post-increments both pointers, decrements count while nonzero.
// RULE8: Next command is accepted only after the final block byte is moved.
// RULE9: Software keeps destination plus count within 16 bits, no wrap.
// RULE10: Exception entry pushes program counter and flags via the stack pointer.
// RULE11: Halt with standby select set stops all and resets modules; state kept.
// RULE12: Low standby pin halts everything including ports, resets modules, keeps RAM.
// RULE13: One state is one clock; each bus cycle lasts two or three states.
// RULE14: On-chip memory cycles take two states over sixteen bits, byte or word; here the bus is 8 bits, one byte per cycle.
// RULE15: Register field and external cycles take three states, one byte each.
// RULE16: Word access to the slow region is two byte cycles, six states.
// RULE17: Mode pins decode to expanded no-ROM, expanded ROM, or single-chip.
// RULE18: In expanded modes a clear RAM gate sends RAM range off-chip.
// RULE19: Expanded modes address at most 64 kbytes off-chip.
// RULE20: Single-chip mode uses only on-chip areas; all ports are general I/O.
// RULE21: System never presents mode zero and keeps the mode pins steady.
// RULE22: System control read/write at FFC4; mode control read-only at FFC5.
// RULE23: Standby select bit picks sleep (0) or software standby (1).
// RULE24: RAM gate bit enables RAM; reset initialises it, standby does not.
// RULE25: Bus states advance one per rising clock edge with no wait states.
module cpu_state_bus_mode_control (
	input  wire        clk_sys_i,
	input  wire        rst_n_i,
	input  wire        hw_standby_pin_n_i,
	input  wire        mode_pin_hi_i,
	input  wire        mode_pin_lo_i,
	input  wire        wake_i,
	input  wire [15:0] reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	output wire        busy_o,
	output wire        sleep_o,
	output wire        sw_standby_o,
	output wire        hw_standby_o,
	output wire        module_reset_o,
	output wire        port_enable_o,
	output wire        rom_enable_o,
	output wire        expanded_o,
	output wire        mem_req_o,
	output reg  [15:0] mem_addr_o,
	output reg  [7:0]  mem_wdata_o,
	output reg         mem_we_o,
	output wire        mem_fast_o,
	output wire        mem_offchip_o,
	output wire [1:0]  mem_state_o,
	input  wire [7:0]  mem_rdata_i
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam [5:0] S_IDLE  = 6'h01;
localparam [5:0] S_RD    = 6'h02;
localparam [5:0] S_WR    = 6'h04;
localparam [5:0] S_PUSH  = 6'h08;
localparam [5:0] S_POP   = 6'h10;
localparam [5:0] S_SLEEP = 6'h20;

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg  [5:0]  state_r;
reg  [1:0]  tstate_r;
reg  [2:0]  step_r;
reg  [7:0]  sysctl_r;
reg  [7:0]  cond_code_reg_r;
reg  [7:0]  imm_r;
reg  [7:0]  greg_r;
reg  [7:0]  block_count_reg_r;
reg  [15:0] block_src_ptr_r;
reg  [15:0] block_dst_ptr_r;
reg  [15:0] stack_ptr_reg_r;
reg  [15:0] pc_r;
reg  [7:0]  move_byte_r;
reg  [7:0]  rdata_nxt;
reg         swsb_r;

// ----------------------------------------------------------------------
// Decode wires
// ----------------------------------------------------------------------
wire       mode_exp   = mode_pin_hi_i ^ mode_pin_lo_i;
wire       ram_gate   = sysctl_r[`SYSCTL_RAM_GATE_BIT];
wire       cyc_active = (state_r != S_IDLE) && (state_r != S_SLEEP) && hw_standby_pin_n_i;
wire       cyc_last;
wire [1:0] cyc_len;

// ----------------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------------
function is_fast;
	input [15:0] a;
	input        exp_mode;
	input        rom_on;
	input        onchip_ram_gate;
	begin
		// RAM when gated in or single-chip, ROM when enabled
		is_fast = ((a >= `RAM_LO_ADDR) && (a <= `RAM_HI_ADDR) && (onchip_ram_gate || !exp_mode)) ||
			((a <= `ROM_HI_ADDR) && rom_on); // RULE18 RULE20
	end
endfunction

function [15:0] ptr_inc;
	input [15:0] p;
	begin
		ptr_inc = p + 16'h0001;
	end
endfunction

function [15:0] ptr_dec;
	input [15:0] p;
	begin
		ptr_dec = p - 16'h0001;
	end
endfunction

// ----------------------------------------------------------------------
// Mode, power-down and bus outputs
// ----------------------------------------------------------------------
assign rom_enable_o  = mode_pin_hi_i;                           // RULE17
assign expanded_o    = mode_exp;                                // RULE17 RULE19
assign port_enable_o = hw_standby_pin_n_i;                      // RULE12 RULE20
assign hw_standby_o  = !hw_standby_pin_n_i;                     // RULE12
assign sleep_o       = (state_r == S_SLEEP) && !swsb_r;         // RULE2
assign sw_standby_o  = (state_r == S_SLEEP) && swsb_r;          // RULE11
assign module_reset_o = sw_standby_o || hw_standby_o;           // RULE11 RULE12
assign busy_o        = (state_r != S_IDLE);                     // RULE8
assign mem_req_o     = cyc_active;
assign mem_fast_o    = is_fast(mem_addr_o, mode_exp, mode_pin_hi_i, ram_gate); // RULE14
assign mem_offchip_o = cyc_active && mode_exp && !mem_fast_o &&
	(mem_addr_o < `REGF_LO_ADDR);                               // RULE18 RULE19
assign cyc_len       = mem_fast_o ? 2'd`FAST_STATES : 2'd`SLOW_STATES; // RULE13 RULE15 RULE16
assign cyc_last      = cyc_active && (tstate_r == cyc_len - 2'd1);
assign mem_state_o   = cyc_active ? tstate_r + 2'd1 : 2'd0;

// ----------------------------------------------------------------------
// Bus state counter
// ----------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		tstate_r <= 2'd0;
	end else if (!cyc_active || cyc_last) begin
		// Clears the state count when no cycle runs or at the last state of a cycle
		tstate_r <= 2'd0;
	end else begin
		tstate_r <= tstate_r + 2'd1; // RULE25 RULE13
	end
end

// ----------------------------------------------------------------------
// Sequencer and registers
// ----------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		state_r           <= S_IDLE;
		step_r            <= 3'd0;
		sysctl_r          <= `SYSCTL_RST;
		cond_code_reg_r   <= `FLAGS_RST;
		imm_r             <= 8'h00;
		greg_r            <= 8'h00;
		block_count_reg_r <= 8'h00;
		block_src_ptr_r   <= 16'h0000;
		block_dst_ptr_r   <= 16'h0000;
		stack_ptr_reg_r   <= 16'h0000;
		pc_r              <= 16'h0000;
		move_byte_r       <= 8'h00;
		mem_addr_o        <= 16'h0000;
		mem_wdata_o       <= 8'h00;
		mem_we_o          <= 1'b0;
		swsb_r            <= 1'b0;
	end else if (!hw_standby_pin_n_i) begin
		// Standby pin aborts any cycle and drops to idle
		state_r  <= S_IDLE; // RULE12
		mem_we_o <= 1'b0;
	end else begin
		case (state_r)
		S_IDLE: begin
			if (reg_wr_i) begin
				case (reg_addr_i)
				`SYSCTL_ADDR: sysctl_r <= (reg_wdata_i & `SYSCTL_WMASK) |
					(sysctl_r & ~`SYSCTL_WMASK); // RULE22 RULE23 RULE24
				`FLAGS_ADDR:  cond_code_reg_r <= reg_wdata_i;
				`IMM_ADDR:    imm_r <= reg_wdata_i;
				`GREG_ADDR:   greg_r <= reg_wdata_i;
				`CNT_ADDR:    block_count_reg_r <= reg_wdata_i;
				`SRC_HI_ADDR: block_src_ptr_r[15:8] <= reg_wdata_i;
				`SRC_LO_ADDR: block_src_ptr_r[7:0] <= reg_wdata_i;
				`DST_HI_ADDR: block_dst_ptr_r[15:8] <= reg_wdata_i;
				`DST_LO_ADDR: block_dst_ptr_r[7:0] <= reg_wdata_i;
				`SP_HI_ADDR:  stack_ptr_reg_r[15:8] <= reg_wdata_i;
				`SP_LO_ADDR:  stack_ptr_reg_r[7:0] <= reg_wdata_i;
				`PC_HI_ADDR:  pc_r[15:8] <= reg_wdata_i;
				`PC_LO_ADDR:  pc_r[7:0] <= reg_wdata_i;
				`CMD_ADDR: begin
					case (reg_wdata_i)
					`OP_NOP:     pc_r <= pc_r + `NOP_PC_STEP; // RULE6
					`OP_FLAG_LD_IMM: cond_code_reg_r <= imm_r; // RULE3
					`OP_FLAG_LD_REG: cond_code_reg_r <= greg_r; // RULE3
					`OP_FLAG_ST:     greg_r <= cond_code_reg_r; // RULE4
					`OP_FLAG_AND:    cond_code_reg_r <= cond_code_reg_r & imm_r; // RULE5
					`OP_FLAG_OR:     cond_code_reg_r <= cond_code_reg_r | imm_r; // RULE5
					`OP_FLAG_XOR:    cond_code_reg_r <= cond_code_reg_r ^ imm_r; // RULE5
					`OP_SLEEP: begin
						swsb_r  <= sysctl_r[`SYSCTL_STANDBY_SEL_BIT]; // RULE23
						state_r <= S_SLEEP; // RULE2 RULE11
					end
					`OP_MOVE: begin
						if (block_count_reg_r != 8'h00) begin // RULE7
							mem_addr_o <= block_src_ptr_r;
							mem_we_o   <= 1'b0;
							state_r    <= S_RD;
						end
					end
					`OP_IRQ: begin
						stack_ptr_reg_r <= ptr_dec(stack_ptr_reg_r);
						mem_addr_o      <= ptr_dec(stack_ptr_reg_r); // RULE10
						mem_wdata_o     <= pc_r[7:0];
						mem_we_o        <= 1'b1;
						step_r          <= 3'd0;
						state_r         <= S_PUSH;
					end
					`OP_EXC_RET: begin
						mem_addr_o <= stack_ptr_reg_r; // RULE1
						mem_we_o   <= 1'b0;
						step_r     <= 3'd0;
						state_r    <= S_POP;
					end
					default: ;
					endcase
				end
				default: ;
				endcase
			end
		end
		S_RD: begin
			if (cyc_last) begin
				move_byte_r <= mem_rdata_i;
				mem_wdata_o <= mem_rdata_i;
				mem_addr_o  <= block_dst_ptr_r;
				mem_we_o    <= 1'b1;
				state_r     <= S_WR;
			end
		end
		S_WR: begin
			if (cyc_last) begin
				block_src_ptr_r   <= ptr_inc(block_src_ptr_r); // RULE7
				block_dst_ptr_r   <= ptr_inc(block_dst_ptr_r);
				block_count_reg_r <= block_count_reg_r - 8'h01;
				mem_we_o          <= 1'b0;
				mem_addr_o        <= ptr_inc(block_src_ptr_r);
				state_r           <= (block_count_reg_r == 8'h01) ? S_IDLE : S_RD; // RULE8
			end
		end
		S_PUSH: begin
			if (cyc_last) begin
				// Push order: PC low, PC high, flags (three byte cycles)
				if (step_r == 3'd2) begin
					mem_we_o <= 1'b0;
					state_r  <= S_IDLE; // RULE10
				end else begin
					stack_ptr_reg_r <= ptr_dec(stack_ptr_reg_r);
					mem_addr_o      <= ptr_dec(stack_ptr_reg_r);
					mem_wdata_o     <= (step_r == 3'd0) ? pc_r[15:8] : cond_code_reg_r;
					step_r          <= step_r + 3'd1;
				end
			end
		end
		S_POP: begin
			if (cyc_last) begin
				stack_ptr_reg_r <= ptr_inc(stack_ptr_reg_r);
				mem_addr_o      <= ptr_inc(stack_ptr_reg_r);
				step_r          <= step_r + 3'd1;
				case (step_r)
				3'd0: cond_code_reg_r <= mem_rdata_i; // RULE1
				3'd1: pc_r[15:8] <= mem_rdata_i;
				default: begin
					pc_r[7:0] <= mem_rdata_i;
					state_r   <= S_IDLE;
				end
				endcase
			end
		end
		S_SLEEP: begin
			if (wake_i || (reg_wr_i && reg_addr_i == `CMD_ADDR && reg_wdata_i == `OP_WAKE))
				state_r <= S_IDLE;
		end
		default: state_r <= S_IDLE;
		endcase
	end
end

// ----------------------------------------------------------------------
// Read data select
// ----------------------------------------------------------------------
always @* begin
	rdata_nxt = 8'h00;
	if (reg_rd_i) begin
		case (reg_addr_i)
		`SYSCTL_ADDR:  rdata_nxt = sysctl_r; // RULE22
		`MODECTL_ADDR: rdata_nxt = `MODECTL_FIXED | {6'd0, mode_pin_hi_i, mode_pin_lo_i}; // RULE22
		`FLAGS_ADDR:  rdata_nxt = cond_code_reg_r;
		`IMM_ADDR:    rdata_nxt = imm_r;
		`GREG_ADDR:   rdata_nxt = greg_r;
		`CNT_ADDR:    rdata_nxt = block_count_reg_r;
		`SRC_HI_ADDR: rdata_nxt = block_src_ptr_r[15:8];
		`SRC_LO_ADDR: rdata_nxt = block_src_ptr_r[7:0];
		`DST_HI_ADDR: rdata_nxt = block_dst_ptr_r[15:8];
		`DST_LO_ADDR: rdata_nxt = block_dst_ptr_r[7:0];
		`SP_HI_ADDR:  rdata_nxt = stack_ptr_reg_r[15:8];
		`SP_LO_ADDR:  rdata_nxt = stack_ptr_reg_r[7:0];
		`PC_HI_ADDR:  rdata_nxt = pc_r[15:8];
		`PC_LO_ADDR:  rdata_nxt = pc_r[7:0];
		`STAT_ADDR:   rdata_nxt = {2'b00, state_r};
		default:      rdata_nxt = 8'h00;
		endcase
	end
end

// ----------------------------------------------------------------------
// Read port register
// ----------------------------------------------------------------------
always @(posedge clk_sys_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		reg_rdata_o <= 8'h00;
	end else begin
		reg_rdata_o <= rdata_nxt; // RULE22
	end
end

endmodule // cpu_state_bus_mode_control

`default_nettype wire

// file: test/cpu_ctl_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ctl_defs.vh"
module cpu_ctl_props (
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic        hw_standby_pin_n_i,
	input wire logic        mode_pin_hi_i,
	input wire logic        mode_pin_lo_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        busy_o,
	input wire logic        sw_standby_o,
	input wire logic        hw_standby_o,
	input wire logic        module_reset_o,
	input wire logic        port_enable_o,
	input wire logic        rom_enable_o,
	input wire logic        expanded_o,
	input wire logic        mem_req_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_we_o,
	input wire logic        mem_fast_o,
	input wire logic [1:0]  mem_state_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	AST_HW_STANDBY_PIN_PINS: assert property (
		hw_standby_o == !hw_standby_pin_n_i && port_enable_o == hw_standby_pin_n_i)
		else $error("standby pin decode wrong");
	AST_MOD_RESET: assert property (
		module_reset_o == (sw_standby_o || hw_standby_o)) else $error("module reset wrong");
	AST_MODE_DECODE: assert property (
		rom_enable_o == mode_pin_hi_i && expanded_o == (mode_pin_hi_i ^ mode_pin_lo_i))
		else $error("mode decode wrong");
	AST_FAST_CYCLE: assert property (
		disable iff (!rst_n_i || hw_standby_o)
		mem_state_o == 2'd1 && mem_fast_o |=> mem_state_o == 2'd2 ##1 mem_state_o != 2'd3)
		else $error("fast cycle not two states");
	AST_SLOW_CYCLE: assert property (
		disable iff (!rst_n_i || hw_standby_o)
		mem_state_o == 2'd1 && !mem_fast_o |=> mem_state_o == 2'd2 ##1 mem_state_o == 2'd3)
		else $error("slow cycle not three states");
	AST_ADDR_HOLD: assert property (
		mem_req_o && mem_state_o != 2'd1 |-> $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("bus address moved mid cycle");
	AST_RDATA_IDLE: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
	AST_MODECTL_RD: assert property (
		reg_rd_i && reg_addr_i == `MODECTL_ADDR |=>
		reg_rdata_o == (8'hE4 | {6'h00, mode_pin_hi_i, mode_pin_lo_i}))
		else $error("mode control read wrong");
	AST_HWSTBY_IDLE: assert property (
		hw_standby_o [*2] |-> !mem_req_o && !busy_o) else $error("activity in standby");
	COV_SLOW: cover property (mem_state_o == 2'd3);
	COV_SWSTBY: cover property (sw_standby_o);
	COV_HWSTBY: cover property (hw_standby_o && busy_o);
endmodule // cpu_ctl_props
bind cpu_state_bus_mode_control cpu_ctl_props props_u (.clk_sys_i, .rst_n_i,
	.hw_standby_pin_n_i, .mode_pin_hi_i, .mode_pin_lo_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .busy_o, .sw_standby_o, .hw_standby_o, .module_reset_o, .port_enable_o,
	.rom_enable_o, .expanded_o, .mem_req_o, .mem_addr_o, .mem_we_o, .mem_fast_o,
	.mem_state_o);
`default_nettype wire

// file: test/bus_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model (
	input  wire logic        clk_sys_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic        fast_i,
	input  wire logic [1:0]  state_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r = 8'h00;
	wire        last_st = req_i && (state_i == (fast_i ? 2'd2 : 2'd3));
	always @(posedge clk_sys_i) begin
		if (last_st && we_i)
			mem[addr_i] <= wdata_i;
		if (req_i && !we_i)
			last_r <= mem[addr_i];
	end
	// Released bus shows inverted data
	assign rdata_o = (req_i && !we_i) ? mem[addr_i] : ~last_r;
endmodule // bus_mem_model
`default_nettype wire

// file: test/cpu_state_bus_mode_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "cpu_ctl_defs.vh"
module cpu_state_bus_mode_control_test;
	logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, hw_standby_pin_n_i = 1'b1, wake_i = 1'b0;
	logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0]  reg_wdata_i = 8'h00;
	wire  [7:0]  reg_rdata_o, mem_wdata_o, mem_rdata_i;
	wire  [15:0] mem_addr_o;
	wire  [1:0]  mem_state_o;
	wire         busy_o, sleep_o, sw_standby_o, hw_standby_o, module_reset_o, port_enable_o;
	wire         rom_enable_o, expanded_o, mem_req_o, mem_we_o, mem_fast_o, mem_offchip_o;
	logic        mode_pin_hi_i = 1'b1, mode_pin_lo_i = 1'b0;
	int          bad_count = 0, check_count = 0, cycles = 0;
	cpu_state_bus_mode_control dut_u (.clk_sys_i, .rst_n_i, .hw_standby_pin_n_i,
		.mode_pin_hi_i, .mode_pin_lo_i, .wake_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .busy_o, .sleep_o, .sw_standby_o, .hw_standby_o,
		.module_reset_o, .port_enable_o, .rom_enable_o, .expanded_o, .mem_req_o, .mem_addr_o,
		.mem_wdata_o, .mem_we_o, .mem_fast_o, .mem_offchip_o, .mem_state_o, .mem_rdata_i);
	bus_mem_model mem_u (.clk_sys_i(clk_sys_i), .req_i(mem_req_o), .we_i(mem_we_o),
		.fast_i(mem_fast_o), .state_i(mem_state_o), .addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask
	task automatic wr16(input logic [15:0] a, input logic [15:0] v);
		wr8(a, v[15:8]);
		wr8(a + 16'h0001, v[7:0]);
	endtask
	task automatic rc16(input logic [15:0] a, input logic [15:0] e);
		rc(a, e[15:8]);
		rc(a + 16'h0001, e[7:0]);
	endtask
	task automatic cmd(input logic [7:0] op, output int n);
		wr8(`CMD_ADDR, op);
		n = 0;
		#1;
		while (busy_o !== 1'b0 && n < 400) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
	endtask
	task automatic flag_op(input logic [7:0] op, input logic [7:0] v, input logic [7:0] e);
		int n;
		wr8(`IMM_ADDR, v);
		wr8(`GREG_ADDR, ~v);
		cmd(op, n);
		rc(`FLAGS_ADDR, e);
	endtask
	task automatic wake_pulse;
		@(posedge clk_sys_i);
		wake_i <= 1'b1;
		@(posedge clk_sys_i);
		wake_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rc(`SYSCTL_ADDR, 8'h09);
		rc(`MODECTL_ADDR, 8'hE6);
		wr8(`SYSCTL_ADDR, 8'h00);
		rc(`SYSCTL_ADDR, 8'h08);
		wr8(`SYSCTL_ADDR, 8'hFF);
		rc(`SYSCTL_ADDR, 8'hFF);
		wr8(`MODECTL_ADDR, 8'h00);
		rc(`MODECTL_ADDR, 8'hE6);
		rc(16'h1234, 8'h00);
		wr8(`SYSCTL_ADDR, 8'h09);
	endtask
	task automatic t_flags;
		int n;
		flag_op(`OP_FLAG_LD_IMM, 8'h5A, 8'h5A);
		flag_op(`OP_FLAG_AND, 8'h0F, 8'h0A);
		flag_op(`OP_FLAG_OR, 8'h30, 8'h3A);
		flag_op(`OP_FLAG_XOR, 8'hFF, 8'hC5);
		flag_op(`OP_FLAG_LD_REG, 8'h3C, 8'hC3);
		wr8(`GREG_ADDR, 8'h00);
		cmd(`OP_FLAG_ST, n);
		rc(`GREG_ADDR, 8'hC3);
		wr16(`PC_HI_ADDR, 16'h1234);
		cmd(`OP_NOP, n);
		rc16(`PC_HI_ADDR, 16'h1236);
		rc(`FLAGS_ADDR, 8'hC3);
	endtask
	task automatic t_move;
		int n;
		for (int i = 0; i < 3; i++)
			mem_u.mem[16'h0100 + i] = 8'(8'hA0 + i);
		mem_u.mem[16'hF003] = 8'h77;
		wr8(`CNT_ADDR, 8'h03);
		wr16(`SRC_HI_ADDR, 16'h0100);
		wr16(`DST_HI_ADDR, 16'hF000);
		fork
			cmd(`OP_MOVE, n);
			begin
				repeat (4) @(posedge clk_sys_i);
				wr8(`CNT_ADDR, 8'h55);
			end
		join
		chk(n, 16'd15);
		for (int i = 0; i < 3; i++)
			chk(mem_u.mem[16'hF000 + i], 8'hA0 + i);
		chk(mem_u.mem[16'hF003], 8'h77);
		rc(`CNT_ADDR, 8'h00);
		rc16(`SRC_HI_ADDR, 16'h0103);
		rc16(`DST_HI_ADDR, 16'hF003);
		cmd(`OP_MOVE, n);
		rc16(`SRC_HI_ADDR, 16'h0103);
	endtask
	task automatic t_irq;
		int n;
		wr16(`SP_HI_ADDR, 16'hFE00);
		cmd(`OP_IRQ, n);
		chk(n, 16'd6);
		chk({mem_u.mem[16'hFDFF], mem_u.mem[16'hFDFE]}, 16'h3612);
		chk(mem_u.mem[16'hFDFD], 8'hC3);
		rc16(`SP_HI_ADDR, 16'hFDFD);
		flag_op(`OP_FLAG_LD_IMM, 8'h00, 8'h00);
		wr16(`PC_HI_ADDR, 16'h0000);
		cmd(`OP_EXC_RET, n);
		rc(`FLAGS_ADDR, 8'hC3);
		rc16(`PC_HI_ADDR, 16'h1236);
		rc16(`SP_HI_ADDR, 16'hFE00);
	endtask
	task automatic t_sleep;
		wr8(`CMD_ADDR, `OP_SLEEP);
		@(posedge clk_sys_i);
		#1 chk({sleep_o, sw_standby_o, module_reset_o}, 3'b100);
		wake_pulse();
		chk(sleep_o, 1'b0);
		wr8(`SYSCTL_ADDR, 8'h89);
		wr8(`CMD_ADDR, `OP_SLEEP);
		@(posedge clk_sys_i);
		#1 chk({sleep_o, sw_standby_o, module_reset_o}, 3'b011);
		wake_pulse();
		rc(`SYSCTL_ADDR, 8'h89);
		rc(`FLAGS_ADDR, 8'hC3);
	endtask
	task automatic t_mode;
		int n;
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		mode_pin_lo_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rc(`MODECTL_ADDR, 8'hE7);
		#1 chk({rom_enable_o, expanded_o}, 2'b10);
		rc(`SYSCTL_ADDR, 8'h09);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		mode_pin_hi_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		#1 chk({rom_enable_o, expanded_o}, 2'b01);
		wr8(`SYSCTL_ADDR, 8'h08);
		wr16(`SP_HI_ADDR, 16'hFE00);
		fork
			cmd(`OP_IRQ, n);
			begin
				repeat (2) @(posedge clk_sys_i);
				#1 chk(mem_offchip_o, 1'b1);
			end
		join
		chk(n, 16'd9);
	endtask
	task automatic t_hw_standby;
		wr8(`CNT_ADDR, 8'h03);
		wr8(`CMD_ADDR, `OP_MOVE);
		@(posedge clk_sys_i);
		hw_standby_pin_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 chk({busy_o, mem_req_o, port_enable_o, hw_standby_o, module_reset_o}, 5'h03);
		@(posedge clk_sys_i);
		hw_standby_pin_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1 chk({port_enable_o, hw_standby_o}, 2'b10);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_flags();
		t_move();
		t_irq();
		t_sleep();
		t_hw_standby();
		t_mode();
		end_of_test();
	end
endmodule // cpu_state_bus_mode_control_test
`default_nettype wire
